// ---- bt_ctx_pkg.sv ----
// Purpose: shared constants for the bit-test branch / context switch unit
// Assumes: 16-bit program counter, 8 banks of 8 byte registers
// Notes: opcode codes are local to this unit's decoded command port
package bt_ctx_pkg;
    // ------------------------------------------------------------
    // command codes
    // ------------------------------------------------------------
    localparam logic [3:0] OP_NONE = 4'h0;
    localparam logic [3:0] OP_BRANCH_IF_TRUE_THEN_CLEAR = 4'h1;
    localparam logic [3:0] OP_BRANCH_IF_FALSE_THEN_SET = 4'h2;
    localparam logic [3:0] OP_DECREMENT_BRANCH_NONZERO_REG = 4'h3;
    localparam logic [3:0] OP_DECREMENT_BRANCH_NONZERO_MEM = 4'h4;
    localparam logic [3:0] OP_CS_ENTRY = 4'h5;
    localparam logic [3:0] OP_CS_RET = 4'h6;
    localparam logic [3:0] OP_CS_RET_LONG = 4'h7;
    // ------------------------------------------------------------
    // bit operand kinds
    // ------------------------------------------------------------
    localparam logic [2:0] SRC_SADDR = 3'h0;
    localparam logic [2:0] SRC_SFR = 3'h1;
    localparam logic [2:0] SRC_ACC = 3'h2;
    localparam logic [2:0] SRC_IDX = 3'h3;
    localparam logic [2:0] SRC_STATUS_WORD_HIGH = 3'h4;
    localparam logic [2:0] SRC_STATUS_WORD_LOW = 3'h5;
    // ------------------------------------------------------------
    // instruction lengths
    // ------------------------------------------------------------
    localparam logic [15:0] LEN_2 = 16'h0002;
    localparam logic [15:0] LEN_3 = 16'h0003;
    localparam logic [15:0] LEN_4 = 16'h0004;
    // ------------------------------------------------------------
    // bank register slots and field layout
    // ------------------------------------------------------------
    localparam int REG_FOUR = 4;
    localparam int REG_FIVE = 5;
    localparam int REG_SIX = 6;
    localparam int REG_SEVEN = 7;
    localparam int BANKS = 8;
    localparam int REGS_PER_BANK = 8;
    localparam int RBS_LSB = 4;
    localparam int RSS_POS = 5;
    localparam int IE_POS = 1;
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PC_RST = 16'h0000;
    localparam logic [7:0] STATUS_WORD_HIGH_RST = 8'h00;
    localparam logic [7:0] STATUS_WORD_LOW_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
endpackage

// ---- bt_ctx_unit.sv ----
// Purpose: executes bit-test branches, loop decrements and context switches
// Assumes: memory/sfr byte is read ahead and given on mem_rdata_i
// Notes: one command per cycle; every command finishes in that cycle
// Functional notes
// - test-and-clear, saddr/sfr: bit set -> pc+4+disp, clear bit.
// - test-and-clear, A/X/psw half: bit set -> pc+3+disp, clear bit.
// - test-and-set, saddr/sfr: bit clear -> pc+4+disp, set bit.
// - test-and-set, A/X/psw half: bit clear -> pc+3+disp, set bit.
// - status half operands change only the tested bit of that half; others leave flags.
// - register decrement: minus one, branch pc+2+disp if nonzero.
// - memory decrement: write back minus one, branch pc+3+disp if nonzero.
// - entry swaps pc with regs five/four, saves psw into seven/six.
// - entry loads bank select, clears set select and interrupt enable.
// - returns load pc from five/four, then load those with address.
// - returns restore status halves from regs seven and six.
`timescale 1ns/1ps
module bt_ctx_unit
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic cmd_valid_i,
    input wire logic [3:0] cmd_op_i,
    input wire logic [2:0] bit_src_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic [7:0] branch_displacement_i,
    input wire logic [2:0] byte_register_operand_i,
    input wire logic [2:0] bank_number_operand_i,
    input wire logic [15:0] addr16_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] idx_i,
    output logic [15:0] pc_o,
    output logic [7:0] status_word_high_o,
    output logic [7:0] status_word_low_o,
    output logic [2:0] bank_select_field_o,
    output logic register_set_select_o,
    output logic interrupt_enable_flag_o,
    output logic busy_o,
    output logic mem_we_o,
    output logic [7:0] mem_wdata_o,
    output logic acc_we_o,
    output logic idx_we_o,
    output logic [7:0] reg_wdata_o,
    output logic branch_taken_o
);
    import bt_ctx_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] pc_r;
    logic [7:0] status_word_high_r;
    logic [7:0] status_word_low_r;
    logic [7:0] bank_r [BANKS*REGS_PER_BANK];
    logic [2:0] cur_bank;
    logic [5:0] base;
    logic [15:0] disp_ext;
    logic [15:0] len;
    logic [7:0] opnd;
    logic tested;
    logic [7:0] modified;
    logic bt_cmd;
    logic take;
    logic [7:0] dec_val;
    logic [5:0] r4_i;
    logic [5:0] r5_i;
    logic [5:0] r6_i;
    logic [5:0] r7_i;
    logic [5:0] rsel_i;
    logic [5:0] ent_bank;

    assign cur_bank = status_word_high_r[RBS_LSB+2:RBS_LSB];
    assign base = {cur_bank, 3'b000};
    assign r4_i = base + 6'(REG_FOUR);
    assign r5_i = base + 6'(REG_FIVE);
    assign r6_i = base + 6'(REG_SIX);
    assign r7_i = base + 6'(REG_SEVEN);
    assign rsel_i = base + {3'b000, byte_register_operand_i};
    // entry saves into the newly selected bank
    assign ent_bank = {bank_number_operand_i, 3'b000};

    // ------------------------------------------------------------
    // operand select and test
    // ------------------------------------------------------------
    assign disp_ext = {{8{branch_displacement_i[7]}},
                       branch_displacement_i};
    assign bt_cmd = cmd_valid_i &&
                    (cmd_op_i == OP_BRANCH_IF_TRUE_THEN_CLEAR || cmd_op_i == OP_BRANCH_IF_FALSE_THEN_SET);

    always_comb
    begin
        unique case (bit_src_i)
            SRC_SADDR, SRC_SFR: opnd = mem_rdata_i;
            SRC_ACC: opnd = acc_i;
            SRC_IDX: opnd = idx_i;
            SRC_STATUS_WORD_HIGH: opnd = status_word_high_r;
            SRC_STATUS_WORD_LOW: opnd = status_word_low_r;
            default: opnd = mem_rdata_i;
        endcase
    end

    // test and modify computed from one sample, applied in one edge
    assign tested = opnd[bit_sel_i];
    always_comb
    begin
        modified = opnd;
        if (cmd_op_i == OP_BRANCH_IF_TRUE_THEN_CLEAR)
        begin
            modified[bit_sel_i] = 1'b0;
        end
        else
        begin
            modified[bit_sel_i] = 1'b1;
        end
    end

    assign dec_val = (cmd_op_i == OP_DECREMENT_BRANCH_NONZERO_REG) ?
                     bank_r[rsel_i] - 8'h01 : mem_rdata_i - 8'h01;

    // ------------------------------------------------------------
    // branch decision
    // ------------------------------------------------------------
    always_comb
    begin
        take = 1'b0;
        len = LEN_2;
        if (cmd_valid_i)
        begin
            unique case (cmd_op_i)
                OP_BRANCH_IF_TRUE_THEN_CLEAR, OP_BRANCH_IF_FALSE_THEN_SET:
                begin
                    len = (bit_src_i == SRC_SADDR || bit_src_i == SRC_SFR)
                          ? LEN_4 : LEN_3;
                    take = (cmd_op_i == OP_BRANCH_IF_TRUE_THEN_CLEAR) ? tested : !tested;
                end
                OP_DECREMENT_BRANCH_NONZERO_REG:
                begin
                    len = LEN_2;
                    take = (dec_val != 8'h00);
                end
                OP_DECREMENT_BRANCH_NONZERO_MEM:
                begin
                    len = LEN_3;
                    take = (dec_val != 8'h00);
                end
                OP_CS_RET:
                begin
                    len = LEN_3;
                end
                OP_CS_RET_LONG:
                begin
                    len = LEN_4;
                end
                default:
                begin
                    len = LEN_2;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // program counter
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pc_r <= PC_RST;
        end
        else if (cmd_valid_i)
        begin
            if (cmd_op_i == OP_CS_ENTRY)
            begin
                pc_r <= {bank_r[ent_bank + 6'(REG_FIVE)],
                         bank_r[ent_bank + 6'(REG_FOUR)]};
            end
            else if (cmd_op_i == OP_CS_RET || cmd_op_i == OP_CS_RET_LONG)
            begin
                pc_r <= {bank_r[r5_i], bank_r[r4_i]};
            end
            else if (take)
            begin
                pc_r <= pc_r + len + disp_ext;
            end
            // unknown codes are ignored and leave pc where it is
            else if (cmd_op_i inside {OP_BRANCH_IF_TRUE_THEN_CLEAR, OP_BRANCH_IF_FALSE_THEN_SET,
                                      OP_DECREMENT_BRANCH_NONZERO_REG, OP_DECREMENT_BRANCH_NONZERO_MEM})
            begin
                pc_r <= pc_r + len;
            end
        end
    end

    // ------------------------------------------------------------
    // status word halves
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            status_word_high_r <= STATUS_WORD_HIGH_RST;
            status_word_low_r <= STATUS_WORD_LOW_RST;
        end
        else if (cmd_valid_i)
        begin
            if (cmd_op_i == OP_CS_ENTRY)
            begin
                status_word_high_r[RBS_LSB+2:RBS_LSB] <= bank_number_operand_i;
                status_word_high_r[RSS_POS+2] <= 1'b0;
                status_word_high_r[IE_POS] <= 1'b0;
            end
            else if (cmd_op_i == OP_CS_RET || cmd_op_i == OP_CS_RET_LONG)
            begin
                status_word_high_r <= bank_r[r7_i];
                status_word_low_r <= bank_r[r6_i];
            end
            else if (bt_cmd && take && bit_src_i == SRC_STATUS_WORD_HIGH)
            begin
                status_word_high_r <= modified;
            end
            else if (bt_cmd && take && bit_src_i == SRC_STATUS_WORD_LOW)
            begin
                status_word_low_r <= modified;
            end
        end
    end

    // ------------------------------------------------------------
    // bank register file
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            for (int i = 0; i < BANKS*REGS_PER_BANK; i++)
            begin
                bank_r[i] <= BYTE_RST;
            end
        end
        else if (cmd_valid_i)
        begin
            if (cmd_op_i == OP_CS_ENTRY)
            begin
                bank_r[ent_bank + 6'(REG_FIVE)] <= pc_r[15:8];
                bank_r[ent_bank + 6'(REG_FOUR)] <= pc_r[7:0];
                bank_r[ent_bank + 6'(REG_SEVEN)] <= status_word_high_r;
                bank_r[ent_bank + 6'(REG_SIX)] <= status_word_low_r;
            end
            else if (cmd_op_i == OP_CS_RET || cmd_op_i == OP_CS_RET_LONG)
            begin
                bank_r[r5_i] <= addr16_i[15:8];
                bank_r[r4_i] <= addr16_i[7:0];
            end
            else if (cmd_op_i == OP_DECREMENT_BRANCH_NONZERO_REG)
            begin
                bank_r[rsel_i] <= dec_val;
            end
        end
    end

    // ------------------------------------------------------------
    // write-back strobes to memory, sfr, accumulator, index
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mem_we_o <= 1'b0;
            mem_wdata_o <= BYTE_RST;
            acc_we_o <= 1'b0;
            idx_we_o <= 1'b0;
            reg_wdata_o <= BYTE_RST;
            branch_taken_o <= 1'b0;
        end
        else
        begin
            mem_we_o <= (bt_cmd && take && (bit_src_i == SRC_SADDR ||
                         bit_src_i == SRC_SFR)) ||
                        (cmd_valid_i && cmd_op_i == OP_DECREMENT_BRANCH_NONZERO_MEM);
            mem_wdata_o <= (cmd_op_i == OP_DECREMENT_BRANCH_NONZERO_MEM) ? dec_val : modified;
            acc_we_o <= bt_cmd && take && bit_src_i == SRC_ACC;
            idx_we_o <= bt_cmd && take && bit_src_i == SRC_IDX;
            reg_wdata_o <= modified;
            branch_taken_o <= take;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pc_o = pc_r;
    assign status_word_high_o = status_word_high_r;
    assign status_word_low_o = status_word_low_r;
    assign bank_select_field_o = cur_bank;
    assign register_set_select_o = status_word_high_r[RSS_POS+2];
    // own bit, so clearing set select never aliases the enable
    assign interrupt_enable_flag_o = status_word_high_r[IE_POS];
    // never stalls: the read-modify-write is single-cycle
    assign busy_o = 1'b0;
endmodule

// ---- bt_ctx_unit_assertions.sv ----
// Purpose: port checks for the bit-test branch and context switch unit
// Assumes: pc, status and strobes all settle at the command edge
// Notes: bound to every instance of bt_ctx_unit
`timescale 1ns/1ps
module bt_ctx_unit_assertions
    import bt_ctx_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic cmd_valid_i,
    input wire logic [3:0] cmd_op_i,
    input wire logic [2:0] bit_src_i,
    input wire logic [2:0] bit_sel_i,
    input wire logic [7:0] branch_displacement_i,
    input wire logic [2:0] bank_number_operand_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] idx_i,
    input wire logic [15:0] pc_o,
    input wire logic [7:0] status_word_low_o,
    input wire logic [2:0] bank_select_field_o,
    input wire logic register_set_select_o,
    input wire logic interrupt_enable_flag_o,
    input wire logic mem_we_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic acc_we_o,
    input wire logic idx_we_o,
    input wire logic [7:0] reg_wdata_o,
    input wire logic branch_taken_o
);
    logic [15:0] dx;
    logic [7:0] m;
    logic [3:0] op;
    // disp widened here so every branch check adds the same value
    assign dx = {{8{branch_displacement_i[7]}}, branch_displacement_i};
    assign m = 8'h01 << bit_sel_i;
    assign op = cmd_valid_i ? cmd_op_i : OP_NONE;
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    clear_mem_a: assert property (
        op == OP_BRANCH_IF_TRUE_THEN_CLEAR && bit_src_i == SRC_SADDR && (mem_rdata_i & m) != 0
        |=> pc_o == $past(pc_o) + 16'h0004 + $past(dx) && mem_we_o
        && mem_wdata_o == ($past(mem_rdata_i) & ~$past(m)))
        else $error("test-clear on memory bit wrong");
    clear_acc_a: assert property (
        op == OP_BRANCH_IF_TRUE_THEN_CLEAR && bit_src_i == SRC_ACC && (acc_i & m) != 0
        |=> acc_we_o && reg_wdata_o == ($past(acc_i) & ~$past(m)))
        else $error("test-clear on accumulator wrong");
    set_untaken_a: assert property (
        op == OP_BRANCH_IF_FALSE_THEN_SET && bit_src_i == SRC_SFR && (mem_rdata_i & m) != 0
        |=> !mem_we_o && !branch_taken_o && pc_o == $past(pc_o) + 16'h0004)
        else $error("untaken test-set moved wrongly");
    set_idx_a: assert property (
        op == OP_BRANCH_IF_FALSE_THEN_SET && bit_src_i == SRC_IDX && (idx_i & m) == 0
        |=> idx_we_o && reg_wdata_o == ($past(idx_i) | $past(m))
        && pc_o == $past(pc_o) + 16'h0003 + $past(dx))
        else $error("test-set on index wrong");
    low_flags_a: assert property (
        op == OP_BRANCH_IF_FALSE_THEN_SET && bit_src_i == SRC_STATUS_WORD_LOW && (status_word_low_o & m) == 0
        |=> status_word_low_o == ($past(status_word_low_o) | $past(m)))
        else $error("low status half not updated");
    reg_loop_a: assert property (
        op == OP_DECREMENT_BRANCH_NONZERO_REG |=> pc_o == $past(pc_o)
        + (branch_taken_o ? 16'h0002 + $past(dx) : 16'h0002))
        else $error("register loop target wrong");
    mem_loop_a: assert property (
        op == OP_DECREMENT_BRANCH_NONZERO_MEM |=> mem_we_o
        && mem_wdata_o == $past(mem_rdata_i) - 8'h01
        && branch_taken_o == ($past(mem_rdata_i) != 8'h01))
        else $error("memory loop wrong");
    entry_bank_a: assert property (
        op == OP_CS_ENTRY |=> bank_select_field_o == $past(bank_number_operand_i)
        && !register_set_select_o && !interrupt_enable_flag_o)
        else $error("entry state wrong");
    idle_hold_a: assert property (
        op == OP_NONE |=> $stable(pc_o) && !mem_we_o && !acc_we_o && !idx_we_o)
        else $error("idle cycle changed state");
    cover property (op == OP_CS_ENTRY);
    cover property (op == OP_CS_RET_LONG);
    cover property (op == OP_DECREMENT_BRANCH_NONZERO_MEM ##1 branch_taken_o);
endmodule

bind bt_ctx_unit bt_ctx_unit_assertions u_chk (.sys_clk_i, .rstn_i,
    .cmd_valid_i, .cmd_op_i, .bit_src_i, .bit_sel_i, .branch_displacement_i,
    .bank_number_operand_i, .mem_rdata_i, .acc_i, .idx_i, .pc_o,
    .status_word_low_o, .bank_select_field_o, .register_set_select_o,
    .interrupt_enable_flag_o, .mem_we_o, .mem_wdata_o, .acc_we_o, .idx_we_o,
    .reg_wdata_o, .branch_taken_o);

// ---- bit_test_branch_and_context_switch_test.sv ----
// Purpose: directed test of the bit-test branch and context switch unit
// Assumes: bank registers start at zero after reset
// Notes: one command every two cycles, results read at the next fall
`timescale 1ns/1ps
module bit_test_branch_and_context_switch_test;
    import bt_ctx_pkg::*;
    logic sys_clk_i, rstn_i, cmd_valid_i;
    logic [3:0] cmd_op_i;
    logic [2:0] bit_src_i, bit_sel_i, byte_register_operand_i;
    logic [2:0] bank_number_operand_i, bank_select_field_o;
    logic [7:0] branch_displacement_i, mem_rdata_i, acc_i, idx_i;
    logic [15:0] addr16_i, pc_o, pc;
    logic [7:0] status_word_high_o, status_word_low_o, mem_wdata_o;
    logic [7:0] reg_wdata_o;
    logic register_set_select_o, interrupt_enable_flag_o, busy_o;
    logic mem_we_o, acc_we_o, idx_we_o, branch_taken_o;
    int err_total, checks_done;
    bt_ctx_unit u_bt_ctx_unit (.sys_clk_i, .rstn_i, .cmd_valid_i, .cmd_op_i,
        .bit_src_i, .bit_sel_i, .branch_displacement_i,
        .byte_register_operand_i, .bank_number_operand_i, .addr16_i,
        .mem_rdata_i, .acc_i, .idx_i, .pc_o, .status_word_high_o,
        .status_word_low_o, .bank_select_field_o, .register_set_select_o,
        .interrupt_enable_flag_o, .busy_o, .mem_we_o, .mem_wdata_o, .acc_we_o,
        .idx_we_o, .reg_wdata_o, .branch_taken_o);
    always #10 sys_clk_i = ~sys_clk_i;
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
            err_total++;
        end
    endtask
    task automatic run(input logic [3:0] op, input logic [2:0] src,
        input logic [2:0] b, input logic [7:0] d, input logic [7:0] rd);
        @(negedge sys_clk_i);
        cmd_valid_i = 1'b1;
        cmd_op_i = op;
        bit_src_i = src;
        bit_sel_i = b;
        branch_displacement_i = d;
        mem_rdata_i = rd;
        acc_i = rd;
        idx_i = rd;
        @(negedge sys_clk_i);
        cmd_valid_i = 1'b0;
    endtask
    task automatic stop_test();
        if (err_total == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // ------------------------------------------------
    // sequence
    // ------------------------------------------------
    initial
    begin
        {sys_clk_i, rstn_i, cmd_valid_i, cmd_op_i, bit_src_i, bit_sel_i} = 0;
        {branch_displacement_i, mem_rdata_i, acc_i, idx_i, addr16_i} = 0;
        {byte_register_operand_i, bank_number_operand_i} = 6'h02;
        err_total = 0;
        checks_done = 0;
        repeat (12) @(negedge sys_clk_i);
        rstn_i = 1'b1;
        check(pc_o, 16'h0000);
        check(busy_o, 16'h0000);
        run(OP_BRANCH_IF_TRUE_THEN_CLEAR, SRC_SADDR, 3'h2, 8'hF0, 8'h04);
        check(pc_o, 16'hFFF4);
        check(mem_we_o, 16'h0001);
        check(mem_wdata_o, 16'h0000);
        run(OP_BRANCH_IF_TRUE_THEN_CLEAR, SRC_ACC, 3'h5, 8'h10, 8'h04);
        check(acc_we_o, 16'h0000);
        run(OP_BRANCH_IF_TRUE_THEN_CLEAR, SRC_ACC, 3'h2, 8'h01, 8'h04);
        check(pc_o, 16'hFFFB);
        check(reg_wdata_o, 16'h0000);
        run(OP_BRANCH_IF_FALSE_THEN_SET, SRC_SFR, 3'h7, 8'h20, 8'h01);
        check(mem_wdata_o, 16'h0081);
        run(OP_BRANCH_IF_FALSE_THEN_SET, SRC_SFR, 3'h0, 8'h20, 8'h01);
        check(pc_o, 16'h0023);
        run(OP_BRANCH_IF_FALSE_THEN_SET, SRC_IDX, 3'h0, 8'h02, 8'h10);
        check(reg_wdata_o, 16'h0011);
        check(idx_we_o, 16'h0001);
        run(OP_BRANCH_IF_FALSE_THEN_SET, SRC_STATUS_WORD_LOW, 3'h3, 8'h00, 8'h00);
        check(status_word_low_o, 16'h0008);
        run(OP_BRANCH_IF_FALSE_THEN_SET, SRC_STATUS_WORD_HIGH, 3'h0, 8'h00, 8'h00);
        check(status_word_high_o, 16'h0001);
        run(OP_DECREMENT_BRANCH_NONZERO_REG, SRC_SADDR, 3'h0, 8'h08, 8'h00);
        check(pc_o, 16'h0038);
        run(OP_DECREMENT_BRANCH_NONZERO_MEM, SRC_SADDR, 3'h0, 8'h40, 8'h01);
        check(branch_taken_o, 16'h0000);
        run(OP_DECREMENT_BRANCH_NONZERO_MEM, SRC_SADDR, 3'h0, 8'h80, 8'h05);
        check(mem_wdata_o, 16'h0004);
        pc = 16'hFFBE;
        check(pc_o, pc);
        bank_number_operand_i = 3'h3;
        run(OP_CS_ENTRY, SRC_SADDR, 3'h0, 8'h00, 8'h00);
        check(pc_o, 16'h0000);
        check({bank_select_field_o, register_set_select_o,
            interrupt_enable_flag_o}, 16'h000C);
        run(OP_BRANCH_IF_TRUE_THEN_CLEAR, SRC_STATUS_WORD_LOW, 3'h3, 8'h00, 8'h00);
        check(status_word_low_o, 16'h0000);
        addr16_i = 16'h1234;
        run(OP_CS_RET, SRC_SADDR, 3'h0, 8'h00, 8'h00);
        check(pc_o, pc);
        check({status_word_high_o, status_word_low_o}, 16'h0108);
        run(OP_CS_ENTRY, SRC_SADDR, 3'h0, 8'h00, 8'h00);
        check(pc_o, 16'h1234);
        run(OP_NONE, SRC_SADDR, 3'h0, 8'h00, 8'h00);
        check(pc_o, 16'h1234);
        addr16_i = 16'h5678;
        run(OP_CS_RET_LONG, SRC_SADDR, 3'h0, 8'h00, 8'h00);
        check(pc_o, pc);
        stop_test();
    end
    initial
    begin
        // whole sequence needs well under 100 cycles
        repeat (1000) @(posedge sys_clk_i);
        err_total++;
        stop_test();
    end
endmodule
